// ===== verilog/dcw_pkg.sv
// Package for the configuration word decoder: word layouts, register
// offsets, reset values and field codes shared by the decoder modules.
// Assumes the two words come from the nonvolatile store on clk_sys.
package dcw_pkg;

   // ------------------------------------------------------------------
   // Field positions, boot_protect_debug_word
   // ------------------------------------------------------------------
   localparam int W0_CODE_PROTECT = 28;
   localparam int W0_BOOT_WP = 24;
   localparam int W0_PROG_WP_HI = 15;
   localparam int W0_PROG_WP_LO = 10;
   localparam int W0_PAIR_HI = 4;
   localparam int W0_PAIR_LO = 3;
   localparam int W0_BSCAN_EN = 2;
   localparam int W0_MONITOR_HI = 1;
   localparam int W0_MONITOR_LO = 0;
   localparam logic [31:0] W0_RSVD_ONES = 32'h6eff03e0;
   localparam logic [31:0] W0_RSVD_ZERO = 32'h80000000;

   // ------------------------------------------------------------------
   // Field positions, watchdog_clock_config_word
   // ------------------------------------------------------------------
   localparam int W1_WIN_SIZE_HI = 25;
   localparam int W1_WIN_SIZE_LO = 24;
   localparam int W1_WDT_HARD = 23;
   localparam int W1_WIN_OFF = 22;
   localparam int W1_POST_HI = 20;
   localparam int W1_POST_LO = 16;
   localparam int W1_CKSM_HI = 15;
   localparam int W1_CKSM_LO = 14;
   localparam int W1_PBDIV_HI = 13;
   localparam int W1_PBDIV_LO = 12;
   localparam int W1_POSC_HI = 9;
   localparam int W1_POSC_LO = 8;
   localparam int W1_OSC_HI = 2;
   localparam int W1_OSC_LO = 0;
   localparam logic [31:0] W1_RSVD_ONES = 32'hfc200858;

   // ------------------------------------------------------------------
   // Field codes
   // ------------------------------------------------------------------
   localparam logic [5:0] PWP_OFF = 6'h3f;
   localparam logic [5:0] PWP_MAX_STEPS = 6'h20;
   localparam int PWP_STEP_SHIFT = 10;
   localparam logic [4:0] POST_MAX = 5'h14;
   localparam logic [1:0] POSC_DISABLED = 2'h3;
   localparam logic [2:0] OSC_PRIMARY = 3'h2;
   localparam logic [2:0] OSC_PRIMARY_PLL = 3'h3;
   localparam logic [3:0] WIN_EIGHTHS_25 = 4'h2;
   localparam logic [3:0] WIN_EIGHTHS_37 = 4'h3;
   localparam logic [3:0] WIN_EIGHTHS_50 = 4'h4;
   localparam logic [3:0] WIN_EIGHTHS_75 = 4'h6;

   // ------------------------------------------------------------------
   // Register offsets and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_WORD0 = 8'h00;
   localparam logic [7:0] REG_WORD1 = 8'h04;
   localparam logic [7:0] REG_RUNTIME_CTRL = 8'h08;
   localparam logic [7:0] REG_WDT_CTRL = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [31:0] WORD_RESET = 32'hffffffff;
   localparam logic [31:0] RDATA_RESET = 32'h00000000;

endpackage

// ===== verilog/dcw_wdt_clk_decode.sv
// Combinational decode of the watchdog and clock fields of the
// watchdog_clock_config_word. Assumes its input is a held register.
`timescale 1ns/1ps
`default_nettype none
module dcw_wdt_clk_decode
   import dcw_pkg::*;
(
   input wire logic [31:0] word1,
   output logic [3:0] window_eighths,
   output logic windowed,
   output logic [4:0] postscale_shift,
   output logic [3:0] pb_divide_ratio,
   output logic clock_switch_en,
   output logic clock_monitor_en,
   output logic osc_conflict
);

   // ------------------------------------------------------------------
   // Field decode
   // ------------------------------------------------------------------
   logic [4:0] post_code;
   logic [1:0] pb_code;
   logic [1:0] cksm;
   logic [2:0] osc_src;

   // Raw field slices
   assign post_code = word1[W1_POST_HI:W1_POST_LO];
   assign pb_code = word1[W1_PBDIV_HI:W1_PBDIV_LO];
   assign cksm = word1[W1_CKSM_HI:W1_CKSM_LO];
   assign osc_src = word1[W1_OSC_HI:W1_OSC_LO];

   // Open window in eighths of the period
   always_comb begin
      case (word1[W1_WIN_SIZE_HI:W1_WIN_SIZE_LO])
         2'h3: window_eighths = WIN_EIGHTHS_25;
         2'h2: window_eighths = WIN_EIGHTHS_37;
         2'h1: window_eighths = WIN_EIGHTHS_50;
         default: window_eighths = WIN_EIGHTHS_75;
      endcase
   end

   // Window mode, postscale clamp, bus divisor, clock switching
   assign windowed = ~word1[W1_WIN_OFF];
   assign postscale_shift = (post_code > POST_MAX) ? POST_MAX : post_code;
   assign pb_divide_ratio = 4'h1 << pb_code;
   assign clock_switch_en = ~cksm[1];
   assign clock_monitor_en = (cksm == 2'h0);
   // Flags a forbidden pairing so software can see it
   assign osc_conflict = (word1[W1_POSC_HI:W1_POSC_LO] == POSC_DISABLED)
      && ((osc_src == OSC_PRIMARY) || (osc_src == OSC_PRIMARY_PLL));

endmodule
`default_nettype wire

// ===== verilog/dcw_config_decode.sv
// Device configuration word decoder: captures both nonvolatile words
// once per reset, decodes protection, debug, watchdog and clock settings
// and offers a small software register port.
// Assumes nv_word0/nv_word1 are stable outputs of the store on clk_sys.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dcw_config_decode
   import dcw_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] nv_word0,
   input wire logic [31:0] nv_word1,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic ext_read_req,
   output logic ext_read_grant,
   input wire logic flash_write_req,
   input wire logic flash_write_boot,
   input wire logic [15:0] flash_write_addr,
   output logic flash_write_grant,
   output logic config_valid,
   output logic ext_prog_block,
   output logic boot_write_block,
   output logic prog_protect_active,
   output logic [15:0] prog_protect_limit,
   output logic [1:0] debug_pair_index,
   output logic jtag_port_enable,
   output logic debugger_enable,
   output logic [3:0] wdt_window_eighths,
   output logic wdt_run,
   output logic wdt_windowed,
   output logic [4:0] wdt_postscale_shift,
   output logic [3:0] pb_divide_ratio,
   output logic clock_switch_en,
   output logic clock_monitor_en
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic loaded;
      logic [31:0] word0;
      logic [31:0] word1;
      logic jtag_rt;
      logic wdt_sw_en;
      logic [31:0] rdata;
      logic ext_block;
      logic boot_block;
      logic prog_active;
      logic [15:0] prog_limit;
      logic [1:0] pair_index;
      logic debug_en;
      logic [3:0] win_eighths;
      logic windowed;
      logic [4:0] post_shift;
      logic [3:0] pb_ratio;
      logic clk_sw_en;
      logic clk_mon_en;
      logic osc_conflict;
   } dcw_state_type;

   dcw_state_type state_reg;
   dcw_state_type state_next;

   // ------------------------------------------------------------------
   // Watchdog and clock field decode of the next word
   // ------------------------------------------------------------------
   logic [3:0] dec_win_eighths;
   logic dec_windowed;
   logic [4:0] dec_post_shift;
   logic [3:0] dec_pb_ratio;
   logic dec_clk_sw_en;
   logic dec_clk_mon_en;
   logic dec_osc_conflict;
   logic [31:0] next_word0;
   logic [31:0] next_word1;

   // Words the next state will hold; taken from the flops, not the next state, so the decode has no loop
   assign next_word0 = state_reg.loaded ? state_reg.word0 : nv_word0;
   assign next_word1 = state_reg.loaded ? state_reg.word1 : nv_word1;

   dcw_wdt_clk_decode u_wdt_clk_decode (
      .word1(next_word1),
      .window_eighths(dec_win_eighths),
      .windowed(dec_windowed),
      .postscale_shift(dec_post_shift),
      .pb_divide_ratio(dec_pb_ratio),
      .clock_switch_en(dec_clk_sw_en),
      .clock_monitor_en(dec_clk_mon_en),
      .osc_conflict(dec_osc_conflict)
   );

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   logic [5:0] pwp_code;
   logic [5:0] pwp_steps;
   logic code_prot;
   logic rsvd_bad;
   logic [31:0] status_word;

   // Protection fields of the next word0
   assign pwp_code = next_word0[W0_PROG_WP_HI:W0_PROG_WP_LO];
   assign code_prot = ~next_word0[W0_CODE_PROTECT];

   // Reserved pattern check, visible in the status register only
   assign rsvd_bad = ((state_reg.word0 & W0_RSVD_ONES) != W0_RSVD_ONES)
      || ((state_reg.word0 & W0_RSVD_ZERO) != 32'h00000000)
      || ((state_reg.word1 & W1_RSVD_ONES) != W1_RSVD_ONES);

   // Status layout: bit0 loaded, bit1 reserved mismatch, bit2 osc conflict
   assign status_word = {29'h00000000, state_reg.osc_conflict, rsvd_bad, state_reg.loaded};

   always_comb begin
      state_next = state_reg;
      // Capture once, the first cycle after reset release; held afterwards
      if (!state_reg.loaded) begin
         state_next.loaded = 1'b1;
         state_next.word0 = nv_word0;
         state_next.word1 = nv_word1;
         state_next.jtag_rt = nv_word0[W0_BSCAN_EN];
         state_next.wdt_sw_en = 1'b0;
      end
      // Software writes; hard enable pins the watchdog on
      if (reg_wr && state_reg.loaded) begin
         case (reg_addr)
            REG_RUNTIME_CTRL: begin
               state_next.jtag_rt = reg_wdata[0];
            end
            REG_WDT_CTRL: begin
               state_next.wdt_sw_en = reg_wdata[0];
            end
            default: begin
               state_next.jtag_rt = state_reg.jtag_rt;
            end
         endcase
      end
      if (state_next.word1[W1_WDT_HARD] && state_next.loaded) begin
         state_next.wdt_sw_en = 1'b1;
      end
      // Read data stands only the cycle after the strobe
      state_next.rdata = RDATA_RESET;
      if (reg_rd) begin
         case (reg_addr)
            REG_WORD0: state_next.rdata = state_reg.word0;
            REG_WORD1: state_next.rdata = state_reg.word1;
            REG_RUNTIME_CTRL: state_next.rdata = {31'h00000000, state_reg.jtag_rt};
            REG_WDT_CTRL: state_next.rdata = {31'h00000000, state_reg.wdt_sw_en};
            REG_STATUS: state_next.rdata = status_word;
            default: state_next.rdata = RDATA_RESET;
         endcase
      end
      // Protection decode, held in flops beside the words
      state_next.ext_block = code_prot;
      state_next.boot_block = ~state_next.word0[W0_BOOT_WP];
      state_next.prog_active = (pwp_code != PWP_OFF);
      pwp_steps = PWP_OFF - pwp_code;
      // Codes below the last listed one keep the largest boundary
      if (pwp_steps > PWP_MAX_STEPS) begin
         pwp_steps = PWP_MAX_STEPS;
      end
      state_next.prog_limit = {pwp_steps, 10'h000};
      state_next.pair_index = ~state_next.word0[W0_PAIR_HI:W0_PAIR_LO];
      // Protected parts see the monitor field as all ones
      state_next.debug_en = ~state_next.word0[W0_MONITOR_HI] && !code_prot;
      state_next.win_eighths = dec_win_eighths;
      state_next.windowed = dec_windowed;
      state_next.post_shift = dec_post_shift;
      state_next.pb_ratio = dec_pb_ratio;
      state_next.clk_sw_en = dec_clk_sw_en;
      state_next.clk_mon_en = dec_clk_mon_en;
      state_next.osc_conflict = dec_osc_conflict;
      // Until loaded the external block and the debugger enable read as their safest values
      if (!state_next.loaded) begin
         state_next.ext_block = 1'b1;
         state_next.debug_en = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // Reset leaves everything locked down until the words are captured
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.word0 <= WORD_RESET;
         state_reg.word1 <= WORD_RESET;
         state_reg.ext_block <= 1'b1;
         state_reg.boot_block <= 1'b1;
         state_reg.rdata <= RDATA_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Access gates are combinational handshakes on registered settings
   assign ext_read_grant = ext_read_req && !state_reg.ext_block;
   assign flash_write_grant = flash_write_req && state_reg.loaded
      && !(flash_write_boot && state_reg.boot_block)
      && !(!flash_write_boot && state_reg.prog_active
      && (flash_write_addr < state_reg.prog_limit));

   assign reg_rdata = state_reg.rdata;
   assign config_valid = state_reg.loaded;
   assign ext_prog_block = state_reg.ext_block;
   assign boot_write_block = state_reg.boot_block;
   assign prog_protect_active = state_reg.prog_active;
   assign prog_protect_limit = state_reg.prog_limit;
   assign debug_pair_index = state_reg.pair_index;
   assign jtag_port_enable = state_reg.jtag_rt;
   assign debugger_enable = state_reg.debug_en;
   assign wdt_window_eighths = state_reg.win_eighths;
   assign wdt_run = state_reg.wdt_sw_en;
   assign wdt_windowed = state_reg.windowed;
   assign wdt_postscale_shift = state_reg.post_shift;
   assign pb_divide_ratio = state_reg.pb_ratio;
   assign clock_switch_en = state_reg.clk_sw_en;
   assign clock_monitor_en = state_reg.clk_mon_en;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence wdt_off_write_s;
      reg_wr && (reg_addr == REG_WDT_CTRL) && !reg_wdata[0];
   endsequence

   sequence wdt_on_write_s;
      reg_wr && (reg_addr == REG_WDT_CTRL) && reg_wdata[0];
   endsequence

   sequence jtag_write_s;
      reg_wr && (reg_addr == REG_RUNTIME_CTRL);
   endsequence

   sequence wdt_read_s;
      reg_rd && (reg_addr == REG_WDT_CTRL);
   endsequence

   code_protect_a: assert property (config_valid && !state_reg.word0[W0_CODE_PROTECT]
      |-> ext_prog_block && !ext_read_grant)
      else $error("external access not blocked under code protect");
   ext_grant_open_a: assert property (config_valid && state_reg.word0[W0_CODE_PROTECT]
      |-> ext_read_grant == ext_read_req)
      else $error("external access refused without code protect");
   boot_write_a: assert property (flash_write_boot && !state_reg.word0[W0_BOOT_WP]
      |-> !flash_write_grant)
      else $error("boot write granted while protected");
   prog_boundary_a: assert property (config_valid
      && (state_reg.word0[W0_PROG_WP_HI:W0_PROG_WP_LO] == 6'h1f)
      |-> prog_protect_limit == 16'h8000 && prog_protect_active)
      else $error("program boundary wrong for code 011111");
   prog_write_a: assert property (flash_write_req && !flash_write_boot && prog_protect_active
      && (flash_write_addr < prog_protect_limit) |-> !flash_write_grant)
      else $error("protected program write granted");
   prog_off_a: assert property (config_valid
      && (state_reg.word0[W0_PROG_WP_HI:W0_PROG_WP_LO] == PWP_OFF) |-> !prog_protect_active)
      else $error("program protection on with code 111111");
   pair_select_a: assert property (config_valid
      |-> debug_pair_index == ~state_reg.word0[W0_PAIR_HI:W0_PAIR_LO])
      else $error("debug pin pair mismatch");
   jtag_seed_a: assert property ($rose(config_valid)
      |-> jtag_port_enable == state_reg.word0[W0_BSCAN_EN])
      else $error("runtime scan bit not seeded from word");
   jtag_write_a: assert property (config_valid ##0 jtag_write_s
      |=> jtag_port_enable == $past(reg_wdata[0]))
      else $error("runtime scan bit write lost");
   debug_enable_a: assert property (config_valid
      |-> debugger_enable == (!state_reg.word0[W0_MONITOR_HI]
      && state_reg.word0[W0_CODE_PROTECT]))
      else $error("debugger enable wrong");
   window_size_a: assert property (config_valid
      && (state_reg.word1[W1_WIN_SIZE_HI:W1_WIN_SIZE_LO] == 2'h0)
      |-> wdt_window_eighths == WIN_EIGHTHS_75)
      else $error("window size not 75 percent");
   window_quarter_a: assert property (config_valid
      && (state_reg.word1[W1_WIN_SIZE_HI:W1_WIN_SIZE_LO] == 2'h3) |-> wdt_window_eighths == WIN_EIGHTHS_25)
      else $error("window size not 25 percent");
   wdt_hard_a: assert property (config_valid && state_reg.word1[W1_WDT_HARD]
      ##0 wdt_off_write_s |=> wdt_run [*2])
      else $error("hard watchdog stopped by software");
   wdt_soft_a: assert property ($rose(config_valid) && !state_reg.word1[W1_WDT_HARD]
      |-> !wdt_run)
      else $error("soft watchdog running from reset");
   wdt_start_a: assert property (config_valid ##0 wdt_on_write_s |=> wdt_run)
      else $error("software could not start watchdog");
   wdt_read_a: assert property (wdt_read_s |=> reg_rdata == {31'h00000000, $past(wdt_run)})
      else $error("watchdog enable read back wrong");
   window_mode_a: assert property (config_valid
      |-> wdt_windowed == !state_reg.word1[W1_WIN_OFF])
      else $error("window mode mismatch");
   postscale_a: assert property (config_valid
      |-> wdt_postscale_shift == ((state_reg.word1[W1_POST_HI:W1_POST_LO] > POST_MAX)
      ? POST_MAX : state_reg.word1[W1_POST_HI:W1_POST_LO]))
      else $error("postscale shift wrong");
   pb_divide_a: assert property (config_valid
      && (state_reg.word1[W1_PBDIV_HI:W1_PBDIV_LO] == 2'h3)
      |-> pb_divide_ratio == 4'h8)
      else $error("bus divisor not 8");
   pb_divide_one_a: assert property (config_valid
      && (state_reg.word1[W1_PBDIV_HI:W1_PBDIV_LO] == 2'h0) |-> pb_divide_ratio == 4'h1)
      else $error("bus divisor not 1");
   clock_switch_a: assert property (config_valid
      |-> clock_monitor_en == (state_reg.word1[W1_CKSM_HI:W1_CKSM_LO] == 2'h0)
      && clock_switch_en == !state_reg.word1[W1_CKSM_HI])
      else $error("clock switch decode wrong");
   word_hold_a: assert property (config_valid |=> config_valid
      && $stable(state_reg.word0) && $stable(state_reg.word1))
      else $error("configuration words changed after load");
   load_time_a: assert property ($rose(rst_n) |-> ##1 config_valid)
      else $error("words not loaded one cycle after reset");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == RDATA_RESET)
      else $error("read data outside its cycle");

endmodule
`default_nettype wire

// ===== verification/dcwb_prog_model.sv
// Far-side model: the flash programmer that writes both configuration words.
// Assumes the bench hands it raw field draws and holds them through reset.
`timescale 1ns/1ps
`default_nettype none
module dcwb_prog_model
   import dcw_pkg::*;
(
   input wire logic [31:0] draw0,
   input wire logic [31:0] draw1,
   input wire logic bad_write,
   output logic [31:0] word0,
   output logic [31:0] word1
);
   logic [31:0] w1_base;

   // ------------------------------------------------------------------
   // Programming rules
   // ------------------------------------------------------------------
   // Reserved bits of the second word always written high
   assign w1_base = draw1 | W1_RSVD_ONES;

   // Word build; a careless draw never leaves the selected primary stopped
   always_comb begin
      word0 = (draw0 | W0_RSVD_ONES) & ~W0_RSVD_ZERO;
      word1 = w1_base;
      if ((w1_base[2:0] == OSC_PRIMARY || w1_base[2:0] == OSC_PRIMARY_PLL) && w1_base[9:8] == POSC_DISABLED) begin
         word1[9:8] = 2'h2;
      end
      // Deliberate misprogramming, only when a scenario commands it
      if (bad_write) begin
         word0[31] = 1'b1;
         word1[9:8] = POSC_DISABLED;
         word1[2:0] = OSC_PRIMARY;
      end
   end
endmodule
`default_nettype wire

// ===== verification/dcw_config_decode_bench.sv
// Self-checking bench for the configuration word decoder.
// Assumes dcw_pkg and the programmer model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module dcw_config_decode_bench;
   import dcw_pkg::*;
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   typedef struct {string nm; logic [31:0] v;} dcwb_exp_type;
   dcwb_exp_type exp_q[$];
   dcwb_exp_type e;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] draw0 = 32'h0, draw1 = 32'h0, reg_wdata = 32'h0;
   logic bad_write = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, preq = 1'b0;
   logic ext_read_req = 1'b0, flash_write_req = 1'b0, flash_write_boot = 1'b0;
   logic [7:0] reg_addr = 8'h0;
   logic [15:0] flash_write_addr = 16'h0, prog_protect_limit;
   logic [2:0] psel = 3'h0;
   logic [31:0] nv_word0, nv_word1, reg_rdata, w0, w1, seen;
   logic ext_read_grant, flash_write_grant, config_valid, ext_prog_block, boot_write_block, prog_protect_active;
   logic jtag_port_enable, debugger_enable, wdt_run, wdt_windowed, clock_switch_en, clock_monitor_en;
   logic [1:0] debug_pair_index;
   logic [3:0] wdt_window_eighths, pb_divide_ratio;
   logic [4:0] wdt_postscale_shift;
   int err_count = 0;
   int checks = 0;
   localparam logic [3:0] WIN_TAB [4] = '{4'h6, 4'h4, 4'h3, 4'h2};

   always #12.5 clk_sys = ~clk_sys;

   dcw_config_decode uut (.clk_sys, .rst_n, .nv_word0, .nv_word1, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .ext_read_req, .ext_read_grant, .flash_write_req, .flash_write_boot, .flash_write_addr,
      .flash_write_grant, .config_valid, .ext_prog_block, .boot_write_block, .prog_protect_active,
      .prog_protect_limit, .debug_pair_index, .jtag_port_enable, .debugger_enable, .wdt_window_eighths, .wdt_run,
      .wdt_windowed, .wdt_postscale_shift, .pb_divide_ratio, .clock_switch_en, .clock_monitor_en);

   dcwb_prog_model model (.draw0, .draw1, .bad_write, .word0(nv_word0), .word1(nv_word1));

   // ------------------------------------------------------------------
   // Observation and scoreboard
   // ------------------------------------------------------------------
   // Output groups; packing them keeps one note per group in the queue
   always_comb begin
      case (psel)
         3'h0: seen = {8'h0, ext_prog_block, boot_write_block, prog_protect_active, jtag_port_enable, debugger_enable,
            wdt_run, wdt_windowed, clock_switch_en, clock_monitor_en, debug_pair_index, wdt_window_eighths,
            wdt_postscale_shift, pb_divide_ratio};
         3'h1: seen = {16'h0, prog_protect_limit};
         3'h2: seen = reg_rdata;
         3'h3: seen = {30'h0, wdt_run, jtag_port_enable};
         default: seen = {29'h0, config_valid, ext_read_grant, flash_write_grant};
      endcase
   end

   // Oldest note against whatever the flagged cycle shows
   always @(posedge clk_sys) begin
      if (preq) begin
         e = exp_q.pop_front();
         `CHK(e.nm, e.v, seen)
      end
   end

   // Expected decode worked out bit by bit from the word layouts
   function automatic logic [31:0] exp_flags(input logic [31:0] a, input logic [31:0] b, input logic run,
      input logic jt);
      logic [4:0] ps;
      ps = (b[20:16] > 5'h14) ? 5'h14 : b[20:16];
      return {8'h0, ~a[28], ~a[24], a[15:10] != 6'h3f, jt, ~a[1] & a[28], run, ~b[22], ~b[15], b[15:14] == 2'h0,
         ~a[4:3], WIN_TAB[b[25:24]], ps, 4'h1 << b[13:12]};
   endfunction

   // ------------------------------------------------------------------
   // Drivers
   // ------------------------------------------------------------------
   task automatic probe(input logic [2:0] sel, input logic [31:0] v, input string nm);
      @(posedge clk_sys);
      psel <= sel;
      preq <= 1'b1;
      exp_q.push_back('{nm, v});
      @(posedge clk_sys);
      preq <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back('{"rdata", v});
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      psel <= 3'h2;
      preq <= 1'b1;
      @(posedge clk_sys);
      preq <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Words settle two edges before release, as capture needs
   task automatic load(input logic bad, input logic [31:0] set_ones);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      draw0 <= $urandom | set_ones;
      draw1 <= $urandom;
      bad_write <= bad;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      w0 = nv_word0;
      w1 = nv_word1;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end
      else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Tests: random words, last one misprogrammed on purpose
   // ------------------------------------------------------------------
   initial begin
      logic [15:0] lim;
      logic [15:0] fa;
      logic boot;
      void'($urandom(32'hc5e84164));
      // Ten reset edges in all: seven here, three more inside the first load
      repeat (7) @(posedge clk_sys);
      for (int i = 0; i < 16; i++) begin
         load(i == 15, i == 1 ? 32'h0000fc00 : 32'h0);
         lim = w0[15:10] == 6'h3f ? 16'h0 : (w0[15:10] < 6'h1f ? 16'h8000 : {6'h3f - w0[15:10], 10'h0});
         probe(3'h0, exp_flags(w0, w1, w1[23], w0[2]), "flags");
         probe(3'h1, {16'h0, lim}, "limit");
         // Address just below or at the boundary, boot target on alternate pairs
         fa = lim - 16'(i % 2);
         boot = i[1];
         @(posedge clk_sys);
         ext_read_req <= 1'b1;
         flash_write_req <= 1'b1;
         flash_write_boot <= boot;
         flash_write_addr <= fa;
         probe(3'h4, {29'h0, 1'b1, w0[28], boot ? w0[24] : !(w0[15:10] != 6'h3f && fa < lim)}, "grants");
         rd(REG_STATUS, i == 15 ? 32'h7 : 32'h1);
         wr(8'h40, $urandom);
         rd(8'h40, 32'h0);
         wr(REG_WORD1, ~w1);
         rd(REG_WORD1, w1);
         wr(REG_WDT_CTRL, 32'h0);
         wr(REG_RUNTIME_CTRL, {31'h0, ~w0[2]});
         probe(3'h3, {30'h0, w1[23], ~w0[2]}, "wdt_jtag");
         wr(REG_WDT_CTRL, 32'h1);
         probe(3'h3, {30'h0, 1'b1, ~w0[2]}, "wdt_jtag");
         rd(REG_WDT_CTRL, 32'h1);
         rd(REG_RUNTIME_CTRL, {31'h0, ~w0[2]});
         // Store changes after capture must not reach the decode
         draw0 <= ~draw0;
         draw1 <= ~draw1;
         probe(3'h0, exp_flags(w0, w1, 1'b1, ~w0[2]), "held");
         rd(REG_WORD0, w0);
         $display("test %0d done", i);
      end
      tally_and_finish();
   end

   // Hang guard, several times the expected run length
   initial begin
      #(25 * 4000);
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
